// ---- core/arp_device.sv ----
// Converter end of the readout port: conversion timing, result bank and pin drivers.
`timescale 1ns/100ps
module arp_device (
  // System clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // Sampled channel values, channel 1 in the lowest word
  input wire logic [arp_pkg::NUM_CH*arp_pkg::DATA_W-1:0] CH_DATA_I,
  // Pins toward the host
  arp_link_if.dev LNK
);

  // ----------------------------------------------------------------
  // Channel unpacking
  // ----------------------------------------------------------------
  logic [15:0] ch_word [arp_pkg::NUM_CH];

  genvar g;
  generate
    for (g = 0; g < arp_pkg::NUM_CH; g++) begin : g_unpack
      assign ch_word[g] = CH_DATA_I[g*arp_pkg::DATA_W +: arp_pkg::DATA_W];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Conversion control, system clock
  // ----------------------------------------------------------------
  arp_pkg::arp_conv_state_t conv_st_ff, nxt_conv_st;
  logic [1:0] trig_sync_ff, nxt_trig_sync;
  logic trig_prev_ff, nxt_trig_prev;
  logic [9:0] conv_cnt_ff, nxt_conv_cnt;
  logic busy_ff, nxt_busy;
  logic bank_tgl_ff, nxt_bank_tgl;
  logic [15:0] shadow_ff [arp_pkg::NUM_CH];
  logic [15:0] nxt_shadow [arp_pkg::NUM_CH];

  always_comb begin
    nxt_trig_sync = {trig_sync_ff[0], LNK.sample_trigger};
    nxt_trig_prev = trig_sync_ff[1];
    nxt_conv_st = conv_st_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_busy = busy_ff;
    nxt_bank_tgl = bank_tgl_ff;
    nxt_shadow = shadow_ff;
    case (conv_st_ff)
      arp_pkg::CV_IDLE: begin
        // A trigger edge during a conversion is dropped, not queued.
        if (trig_sync_ff[1] && !trig_prev_ff) begin
          nxt_conv_st = arp_pkg::CV_RUN;
          nxt_busy = 1'b1;
          nxt_conv_cnt = arp_pkg::CONV_LAST;
        end
      end
      arp_pkg::CV_RUN: begin
        if (conv_cnt_ff == 10'h000) begin
          nxt_conv_st = arp_pkg::CV_IDLE;
          nxt_busy = 1'b0;
          nxt_shadow = ch_word;
          nxt_bank_tgl = !bank_tgl_ff;
        end else begin
          nxt_conv_cnt = conv_cnt_ff - 10'h001;
        end
      end
      default: begin
        nxt_conv_st = arp_pkg::CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      conv_st_ff <= arp_pkg::CV_IDLE;
      trig_sync_ff <= 2'h0;
      trig_prev_ff <= 1'b0;
      conv_cnt_ff <= 10'h000;
      busy_ff <= 1'b0;
      bank_tgl_ff <= 1'b0;
      shadow_ff <= '{default: 16'h0000};
    end else begin
      conv_st_ff <= nxt_conv_st;
      trig_sync_ff <= nxt_trig_sync;
      trig_prev_ff <= nxt_trig_prev;
      conv_cnt_ff <= nxt_conv_cnt;
      busy_ff <= nxt_busy;
      bank_tgl_ff <= nxt_bank_tgl;
      shadow_ff <= nxt_shadow;
    end
  end

  assign LNK.busy = busy_ff;

  // ----------------------------------------------------------------
  // Link clock synchronisers
  // ----------------------------------------------------------------
  // Reset, bank toggle and the static select straps cross with two flops.
  // The strobes are launched by the host on the falling link clock edge,
  // so they are already synchronous here and are used directly.
  logic [1:0] lrst_ff, nxt_lrst;
  logic [1:0] tgl_sync_ff, nxt_tgl_sync;
  logic [2:0] strap_meta_ff, nxt_strap_meta;
  logic [2:0] strap_ff, nxt_strap;
  logic link_rst_n;

  always_comb begin
    nxt_lrst = {lrst_ff[0], RESET_N_I};
    nxt_tgl_sync = {tgl_sync_ff[0], bank_tgl_ff};
    nxt_strap_meta = {LNK.iface_sel_a, LNK.iface_sel_b, LNK.byte_order_sel};
    nxt_strap = strap_meta_ff;
  end

  always_ff @(posedge LNK.link_clk) begin
    lrst_ff <= nxt_lrst;
    tgl_sync_ff <= nxt_tgl_sync;
    strap_meta_ff <= nxt_strap_meta;
    strap_ff <= nxt_strap;
  end

  assign link_rst_n = lrst_ff[1];

  // ----------------------------------------------------------------
  // Readout engine, link clock
  // ----------------------------------------------------------------
  logic tgl_seen_ff, nxt_tgl_seen;
  logic cs_prev_ff, nxt_cs_prev;
  logic rd_prev_ff, nxt_rd_prev;
  logic [15:0] bank_ff [arp_pkg::NUM_CH];
  logic [15:0] nxt_bank [arp_pkg::NUM_CH];
  logic [3:0] rd_cnt_ff, nxt_rd_cnt;
  logic [2:0] ser_idx_ff, nxt_ser_idx;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [15:0] sh_a_ff, nxt_sh_a;
  logic [15:0] sh_b_ff, nxt_sh_b;
  logic [15:0] word_ff, nxt_word;
  logic flag_ff, nxt_flag;
  logic lo_oe_n_ff, nxt_lo_oe_n;
  logic hi_oe_n_ff, nxt_hi_oe_n;
  logic flag_oe_n_ff, nxt_flag_oe_n;
  logic ser_oe_n_ff, nxt_ser_oe_n;
  logic [1:0] mode;
  logic cs_fall;
  logic rd_fall;
  logic take_hi;
  logic [2:0] idx_up;
  logic [15:0] cur;

  always_comb begin
    mode = strap_ff[2:1];
    cs_fall = cs_prev_ff && !LNK.cs_n;
    rd_fall = rd_prev_ff && !LNK.rd_n;
    idx_up = ser_idx_ff + 3'h1;
    cur = bank_ff[rd_cnt_ff[2:0]];
    take_hi = rd_cnt_ff[0] ^ strap_ff[0];
    nxt_tgl_seen = tgl_sync_ff[1];
    nxt_cs_prev = LNK.cs_n;
    nxt_rd_prev = LNK.rd_n;
    nxt_bank = bank_ff;
    nxt_rd_cnt = rd_cnt_ff;
    nxt_ser_idx = ser_idx_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_sh_a = sh_a_ff;
    nxt_sh_b = sh_b_ff;
    nxt_word = word_ff;
    nxt_flag = flag_ff;
    // Drivers follow select; once it is high every line floats again.
    nxt_lo_oe_n = !(!LNK.cs_n && (mode == arp_pkg::MODE_PAR || mode == arp_pkg::MODE_BYTE));
    nxt_hi_oe_n = !(!LNK.cs_n && mode == arp_pkg::MODE_PAR);
    nxt_flag_oe_n = !(!LNK.cs_n && mode != 2'h1);
    nxt_ser_oe_n = !(!LNK.cs_n && mode == arp_pkg::MODE_SER);
    if (tgl_sync_ff[1] != tgl_seen_ff) begin
      // The bank only moves once the toggle sent when busy falls has crossed; until then reads see the old sample.
      nxt_bank = shadow_ff;
      nxt_rd_cnt = 4'h0;
      nxt_ser_idx = 3'h0;
      nxt_bit_cnt = 4'h0;
    end else begin
      case (mode)
        arp_pkg::MODE_PAR: begin
          if (!LNK.cs_n && rd_fall) begin
            nxt_word = cur;
            nxt_flag = rd_cnt_ff[2:0] == 3'h0;
            nxt_rd_cnt = {1'b0, rd_cnt_ff[2:0] + 3'h1};
          end else if (cs_fall) begin
            nxt_flag = 1'b0;
          end
        end
        arp_pkg::MODE_BYTE: begin
          if (!LNK.cs_n && rd_fall) begin
            nxt_word = {8'h00, take_hi ? bank_ff[rd_cnt_ff[3:1]][15:8]
                                       : bank_ff[rd_cnt_ff[3:1]][7:0]};
            nxt_flag = rd_cnt_ff[3:1] == 3'h0;
            nxt_rd_cnt = rd_cnt_ff + 4'h1;
          end else if (cs_fall) begin
            nxt_flag = 1'b0;
          end
        end
        arp_pkg::MODE_SER: begin
          if (LNK.cs_n) begin
            // A finished channel framed on its own moves on to the next one.
            if (bit_cnt_ff == arp_pkg::LAST_BIT) begin
              nxt_ser_idx = idx_up;
              nxt_bit_cnt = 4'h0;
            end
          end else if (cs_fall) begin
            nxt_sh_a = bank_ff[ser_idx_ff];
            nxt_sh_b = bank_ff[ser_idx_ff ^ arp_pkg::UPPER_SET];
            nxt_bit_cnt = 4'h0;
            nxt_flag = ser_idx_ff == 3'h0;
          end else if (bit_cnt_ff == arp_pkg::LAST_BIT) begin
            nxt_ser_idx = idx_up;
            nxt_sh_a = bank_ff[idx_up];
            nxt_sh_b = bank_ff[idx_up ^ arp_pkg::UPPER_SET];
            nxt_bit_cnt = 4'h0;
            nxt_flag = idx_up == 3'h0;
          end else begin
            nxt_sh_a = {sh_a_ff[14:0], 1'b0};
            nxt_sh_b = {sh_b_ff[14:0], 1'b0};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end
        end
        default: begin
          nxt_flag = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge LNK.link_clk) begin
    if (!link_rst_n) begin
      tgl_seen_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      bank_ff <= '{default: 16'h0000};
      rd_cnt_ff <= 4'h0;
      ser_idx_ff <= 3'h0;
      bit_cnt_ff <= 4'h0;
      sh_a_ff <= 16'h0000;
      sh_b_ff <= 16'h0000;
      word_ff <= 16'h0000;
      flag_ff <= 1'b0;
      lo_oe_n_ff <= 1'b1;
      hi_oe_n_ff <= 1'b1;
      flag_oe_n_ff <= 1'b1;
      ser_oe_n_ff <= 1'b1;
    end else begin
      tgl_seen_ff <= nxt_tgl_seen;
      cs_prev_ff <= nxt_cs_prev;
      rd_prev_ff <= nxt_rd_prev;
      bank_ff <= nxt_bank;
      rd_cnt_ff <= nxt_rd_cnt;
      ser_idx_ff <= nxt_ser_idx;
      bit_cnt_ff <= nxt_bit_cnt;
      sh_a_ff <= nxt_sh_a;
      sh_b_ff <= nxt_sh_b;
      word_ff <= nxt_word;
      flag_ff <= nxt_flag;
      lo_oe_n_ff <= nxt_lo_oe_n;
      hi_oe_n_ff <= nxt_hi_oe_n;
      flag_oe_n_ff <= nxt_flag_oe_n;
      ser_oe_n_ff <= nxt_ser_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  assign LNK.word_bus_out = word_ff;
  assign LNK.word_bus_lo_oe_n = lo_oe_n_ff;
  assign LNK.word_bus_hi_oe_n = hi_oe_n_ff;
  assign LNK.first_channel_flag_out = flag_ff;
  assign LNK.first_channel_flag_oe_n = flag_oe_n_ff;
  assign LNK.serial_out_lo_set_out = sh_a_ff[15];
  assign LNK.serial_out_hi_set_out = sh_b_ff[15];
  assign LNK.serial_oe_n = ser_oe_n_ff;

endmodule

// ---- core/arp_host.sv ----
// Host end of the readout port: link clock divider, strobes and result capture.
`timescale 1ns/100ps
module arp_host (
  // System clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // Commands
  input wire logic TRIGGER_I,
  input wire logic READ_I,
  input wire logic [1:0] MODE_I,
  input wire logic HI_FIRST_I,
  input wire logic DUAL_LINE_I,
  // Status and results
  output logic BUSY_O,
  output logic DONE_O,
  output logic [arp_pkg::NUM_CH*arp_pkg::DATA_W-1:0] RESULT_O,
  // Pins toward the converter
  arp_link_if.host LNK
);

  arp_pkg::arp_host_state_t st_ff, nxt_st;
  logic ph_ff, nxt_ph;
  logic cs_n_ff, nxt_cs_n;
  logic rd_n_ff, nxt_rd_n;
  logic [2:0] trig_cnt_ff, nxt_trig_cnt;
  logic trig_ff, nxt_trig;
  logic [1:0] busy_sync_ff, nxt_busy_sync;
  logic [2:0] strap_ff, nxt_strap;
  logic dual_ff, nxt_dual;
  logic pend_ff, nxt_pend;
  logic done_ff, nxt_done;
  logic [6:0] beat_ff, nxt_beat;
  logic [6:0] last;
  logic [15:0] res_ff [arp_pkg::NUM_CH];
  logic [15:0] nxt_res [arp_pkg::NUM_CH];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Strobes change and data is sampled only on falling link clock edges,
  // which leaves the converter half a period of setup either way.
  always_comb begin
    // Written as a branch so the divider also starts from an unknown value.
    if (ph_ff) begin
      nxt_ph = 1'b0;
    end else begin
      nxt_ph = 1'b1;
    end
    nxt_trig_cnt = TRIGGER_I ? arp_pkg::TRIG_HOLD
                 : (trig_cnt_ff != 3'h0 ? trig_cnt_ff - 3'h1 : 3'h0);
    nxt_trig = nxt_trig_cnt != 3'h0;
    nxt_busy_sync = {busy_sync_ff[0], LNK.busy};
    nxt_strap = {MODE_I, HI_FIRST_I};
    nxt_dual = dual_ff;
    nxt_st = st_ff;
    nxt_cs_n = cs_n_ff;
    nxt_rd_n = rd_n_ff;
    nxt_pend = pend_ff || READ_I;
    nxt_done = 1'b0;
    nxt_beat = beat_ff;
    nxt_res = res_ff;
    case (strap_ff[2:1])
      arp_pkg::MODE_PAR: last = arp_pkg::PAR_LAST;
      arp_pkg::MODE_BYTE: last = arp_pkg::BYTE_LAST;
      default: last = dual_ff ? arp_pkg::SER_LAST_DUAL : arp_pkg::SER_LAST_SINGLE;
    endcase
    if (ph_ff) begin
      case (st_ff)
        arp_pkg::HS_IDLE: begin
          if (pend_ff) begin
            nxt_pend = READ_I;
            nxt_cs_n = 1'b0;
            nxt_beat = 7'h00;
            nxt_dual = DUAL_LINE_I;
            nxt_st = strap_ff[2:1] == arp_pkg::MODE_SER ? arp_pkg::HS_SER : arp_pkg::HS_RDLO;
          end
        end
        arp_pkg::HS_RDLO: begin
          nxt_rd_n = 1'b0;
          nxt_st = arp_pkg::HS_RDHI;
        end
        arp_pkg::HS_RDHI: begin
          if (strap_ff[2:1] == arp_pkg::MODE_BYTE) begin
            if (beat_ff[0] ^ strap_ff[0]) begin
              nxt_res[beat_ff[3:1]][15:8] = LNK.word_bus_in[7:0];
            end else begin
              nxt_res[beat_ff[3:1]][7:0] = LNK.word_bus_in[7:0];
            end
          end else begin
            nxt_res[beat_ff[2:0]] = LNK.word_bus_in;
          end
          nxt_rd_n = 1'b1;
          nxt_beat = beat_ff + 7'h01;
          nxt_st = arp_pkg::HS_RDLO;
          if (beat_ff == last) begin
            nxt_cs_n = 1'b1;
            nxt_done = 1'b1;
            nxt_st = arp_pkg::HS_IDLE;
          end
        end
        arp_pkg::HS_SER: begin
          if (dual_ff) begin
            nxt_res[{1'b0, beat_ff[5:4]}][arp_pkg::LAST_BIT - beat_ff[3:0]] =
              LNK.serial_out_lo_set_in;
            nxt_res[{1'b1, beat_ff[5:4]}][arp_pkg::LAST_BIT - beat_ff[3:0]] =
              LNK.serial_out_hi_set_in;
          end else begin
            nxt_res[beat_ff[6:4]][arp_pkg::LAST_BIT - beat_ff[3:0]] =
              LNK.serial_out_lo_set_in;
          end
          nxt_beat = beat_ff + 7'h01;
          if (beat_ff == last) begin
            nxt_cs_n = 1'b1;
            nxt_done = 1'b1;
            nxt_st = arp_pkg::HS_IDLE;
          end
        end
        default: begin
          nxt_st = arp_pkg::HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      st_ff <= arp_pkg::HS_IDLE;
      // The link clock runs through reset, or the converter end never sees it.
      ph_ff <= nxt_ph;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      trig_cnt_ff <= 3'h0;
      trig_ff <= 1'b0;
      busy_sync_ff <= 2'h0;
      strap_ff <= 3'h0;
      dual_ff <= 1'b0;
      pend_ff <= 1'b0;
      done_ff <= 1'b0;
      beat_ff <= 7'h00;
      res_ff <= '{default: 16'h0000};
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      cs_n_ff <= nxt_cs_n;
      rd_n_ff <= nxt_rd_n;
      trig_cnt_ff <= nxt_trig_cnt;
      trig_ff <= nxt_trig;
      busy_sync_ff <= nxt_busy_sync;
      strap_ff <= nxt_strap;
      dual_ff <= nxt_dual;
      pend_ff <= nxt_pend;
      done_ff <= nxt_done;
      beat_ff <= nxt_beat;
      res_ff <= nxt_res;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < arp_pkg::NUM_CH; g++) begin : g_pack
      assign RESULT_O[g*arp_pkg::DATA_W +: arp_pkg::DATA_W] = res_ff[g];
    end
  endgenerate

  assign BUSY_O = busy_sync_ff[1];
  assign DONE_O = done_ff;
  assign LNK.link_clk = ph_ff;
  assign LNK.cs_n = cs_n_ff;
  assign LNK.rd_n = rd_n_ff;
  assign LNK.sample_trigger = trig_ff;
  assign LNK.iface_sel_a = strap_ff[2];
  assign LNK.iface_sel_b = strap_ff[1];
  assign LNK.byte_order_sel = strap_ff[0];

endmodule

// ---- core/arp_link_if.sv ----
// Pin-level link between the converter readout port and its host.
`timescale 1ns/100ps
interface arp_link_if;
  logic link_clk;
  logic cs_n;
  logic rd_n;
  logic sample_trigger;
  logic busy;
  logic iface_sel_a;
  logic iface_sel_b;
  logic byte_order_sel;
  logic [15:0] word_bus_out;
  logic word_bus_lo_oe_n;
  logic word_bus_hi_oe_n;
  logic [15:0] word_bus_in;
  logic first_channel_flag_out;
  logic first_channel_flag_oe_n;
  logic first_channel_flag_in;
  logic serial_out_lo_set_out;
  logic serial_out_hi_set_out;
  logic serial_oe_n;
  logic serial_out_lo_set_in;
  logic serial_out_hi_set_in;

  // A floating line reads low here, as if a weak pull-down held it.
  assign word_bus_in[15:8] = word_bus_hi_oe_n ? 8'h00 : word_bus_out[15:8];
  assign word_bus_in[7:0] = word_bus_lo_oe_n ? 8'h00 : word_bus_out[7:0];
  assign first_channel_flag_in = !first_channel_flag_oe_n && first_channel_flag_out;
  assign serial_out_lo_set_in = !serial_oe_n && serial_out_lo_set_out;
  assign serial_out_hi_set_in = !serial_oe_n && serial_out_hi_set_out;

  modport dev (
    input link_clk, cs_n, rd_n, sample_trigger, iface_sel_a, iface_sel_b, byte_order_sel,
    output busy, word_bus_out, word_bus_lo_oe_n, word_bus_hi_oe_n,
    output first_channel_flag_out, first_channel_flag_oe_n,
    output serial_out_lo_set_out, serial_out_hi_set_out, serial_oe_n
  );

  modport host (
    output link_clk, cs_n, rd_n, sample_trigger, iface_sel_a, iface_sel_b, byte_order_sel,
    input busy, word_bus_in, first_channel_flag_in,
    input serial_out_lo_set_in, serial_out_hi_set_in
  );
endinterface

// ---- core/arp_pkg.sv ----
// Constants, types and timing for the converter result readout port.
//
// Functional notes
// - Busy rises at conversion start, falls when done.
// - Result bank reloads exactly when busy falls (here the shadow loads then, the read bank once the toggle crosses).
// - Reads during busy return previous sample.
// - Two select pins choose parallel, byte, serial.
// - Tied strobes: bus enables, channel 1, marker high.
// - Each read fall presents the next channel.
// - Host drives select and read separately when shared.
// - Separate strobes: marker low at second read.
// - Byte mode: low byte lanes, sixteen reads total.
// - Byte order input high sends high byte first.
// - Byte mode marker high for two reads.
// - Serial, select high: outputs float, clock ignored.
// - Select fall drives MSB, clock rises shift rest.
// - Sixteen clocks per channel, ascending, any framing (here a select fall mid-channel restarts that channel from its MSB).
// - Line A carries 1-4 then 5-8; B reversed.
// - Serial marker high with channel 1, low after 16.
// - Marker also marks channel 5 on line B.
// - Single line read needs 128 serial clocks.
// - Dual line read needs 64 serial clocks.
// - Bus and marker float once strobes return high.
package arp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYCLES = (CONV_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);
  localparam logic [2:0] TRIG_HOLD = 3'h4;

  // ----------------------------------------------------------------
  // Mode codes as {iface_sel_a, iface_sel_b}
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PAR = 2'h0;
  localparam logic [1:0] MODE_BYTE = 2'h3;
  localparam logic [1:0] MODE_SER = 2'h2;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [2:0] UPPER_SET = 3'h4;
  localparam logic [6:0] PAR_LAST = 7'h07;
  localparam logic [6:0] BYTE_LAST = 7'h0F;
  localparam logic [6:0] SER_LAST_SINGLE = 7'h7F;
  localparam logic [6:0] SER_LAST_DUAL = 7'h3F;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic {CV_IDLE, CV_RUN} arp_conv_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_RDLO, HS_RDHI, HS_SER} arp_host_state_t;

endpackage

// ---- dv/arp_link_assertions.sv ----
// Protocol checks on the link between the converter end and the host end.
`timescale 1ns/100ps
module arp_link_assertions (
  // Clocks and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic link_clk,
  // Link signals
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sample_trigger,
  input wire logic busy,
  input wire logic iface_sel_a,
  input wire logic iface_sel_b,
  input wire logic word_bus_lo_oe_n,
  input wire logic word_bus_hi_oe_n,
  input wire logic first_channel_flag_out,
  input wire logic first_channel_flag_oe_n,
  input wire logic serial_oe_n
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  localparam int BUSY_MIN = arp_pkg::CONV_CYCLES - 2;
  localparam int BUSY_MAX = arp_pkg::CONV_CYCLES + 2;
  logic rd_q_ff, nxt_rd_q;
  logic [4:0] rdf_ff, nxt_rdf;
  logic [7:0] run_ff, nxt_run;
  logic [9:0] bsy_ff, nxt_bsy;
  logic par, byt, ser;
  assign par = !iface_sel_a && !iface_sel_b;
  assign byt = iface_sel_a && iface_sel_b;
  assign ser = iface_sel_a && !iface_sel_b;
  always_comb begin
    nxt_rd_q = rd_n;
    nxt_rdf = cs_n ? 5'h0 : rdf_ff + 5'(rd_q_ff && !rd_n);
    nxt_run = first_channel_flag_out ? run_ff + 8'h1 : 8'h0;
    nxt_bsy = busy ? bsy_ff + 10'h1 : 10'h0;
  end
  always_ff @(posedge link_clk) begin
    rd_q_ff <= RESET_N_I ? nxt_rd_q : 1'b1;
    rdf_ff <= RESET_N_I ? nxt_rdf : 5'h0;
    run_ff <= RESET_N_I ? nxt_run : 8'h0;
  end
  always_ff @(posedge CLK_SYS_I) begin
    bsy_ff <= RESET_N_I ? nxt_bsy : 10'h0;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  float_idle_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    cs_n [*2] |-> word_bus_lo_oe_n && word_bus_hi_oe_n && first_channel_flag_oe_n && serial_oe_n)
    else $error("link outputs driven while deselected");
  lanes_on_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    $fell(cs_n) && (par || byt) |=> !word_bus_lo_oe_n && (word_bus_hi_oe_n == byt))
    else $error("bus lanes wrong after select fall");
  ser_quiet_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    ser |-> word_bus_lo_oe_n && word_bus_hi_oe_n) else $error("word bus driven in serial mode");
  ser_on_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    $fell(cs_n) && ser |=> !serial_oe_n) else $error("serial lines idle after select fall");
  par_flag_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    par && !cs_n && $fell(rd_n) |=> first_channel_flag_out == (rdf_ff[2:0] == 3'h1))
    else $error("parallel marker wrong");
  byte_flag_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    byt && !cs_n && $fell(rd_n) |=> first_channel_flag_out == (rdf_ff[3:0] inside {4'h1, 4'h2}))
    else $error("byte marker wrong");
  flag_len_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    $fell(first_channel_flag_out) |-> run_ff == (ser ? 8'h10 : byt ? 8'h04 : 8'h02))
    else $error("marker high for wrong length");
  busy_start_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    $rose(sample_trigger) && !busy |-> ##[1:6] busy) else $error("busy did not rise");
  busy_len_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
    $fell(busy) |-> bsy_ff >= BUSY_MIN && bsy_ff <= BUSY_MAX) else $error("busy length wrong");
  strobe_pair_a: assert property (@(posedge link_clk) disable iff (!RESET_N_I)
    !rd_n |-> !cs_n) else $error("read strobe low while deselected");
endmodule

// ---- dv/tb_adc_result_readout_port.sv ----
// Self-checking bench joining the host end and the converter end of the readout port.
`timescale 1ns/100ps
module tb_adc_result_readout_port;
  logic CLK_SYS_I, RESET_N_I, TRIGGER_I, READ_I, HI_FIRST_I, DUAL_LINE_I, BUSY_O, DONE_O;
  logic [1:0] MODE_I;
  logic [arp_pkg::NUM_CH*arp_pkg::DATA_W-1:0] RESULT_O, ch_data, prev, cur;
  int errors, compares, cyc, seed;
  arp_link_if lnk ();
  arp_device arp_device_inst (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
    .CH_DATA_I(ch_data), .LNK(lnk.dev));
  arp_host arp_host_inst (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .TRIGGER_I(TRIGGER_I),
    .READ_I(READ_I), .MODE_I(MODE_I), .HI_FIRST_I(HI_FIRST_I), .DUAL_LINE_I(DUAL_LINE_I),
    .BUSY_O(BUSY_O), .DONE_O(DONE_O), .RESULT_O(RESULT_O), .LNK(lnk.host));
  arp_link_assertions arp_link_assertions_inst (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
    .link_clk(lnk.link_clk), .cs_n(lnk.cs_n), .rd_n(lnk.rd_n), .busy(lnk.busy),
    .sample_trigger(lnk.sample_trigger), .iface_sel_a(lnk.iface_sel_a),
    .iface_sel_b(lnk.iface_sel_b), .word_bus_lo_oe_n(lnk.word_bus_lo_oe_n),
    .word_bus_hi_oe_n(lnk.word_bus_hi_oe_n), .first_channel_flag_out(lnk.first_channel_flag_out),
    .first_channel_flag_oe_n(lnk.first_channel_flag_oe_n), .serial_oe_n(lnk.serial_oe_n));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] first_byte(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (BUSY_O !== lvl && n < 1000) begin
      @(posedge CLK_SYS_I);
      n++;
    end
    if (n >= 1000) begin
      errors++;
    end
  endtask
  task automatic do_read(input logic [127:0] exp);
    int n;
    n = 0;
    READ_I <= 1'b1;
    @(posedge CLK_SYS_I);
    READ_I <= 1'b0;
    while (DONE_O !== 1'b1 && n < 1000) begin
      @(posedge CLK_SYS_I);
      n++;
    end
    if (n >= 1000) begin
      errors++;
    end
    chk(RESULT_O, exp);
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    CLK_SYS_I = 1'b0;
    forever #5 CLK_SYS_I = ~CLK_SYS_I;
  end
  always @(posedge CLK_SYS_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    seed = 32'had50_9687;
    {errors, compares, cyc} = '0;
    {TRIGGER_I, READ_I, HI_FIRST_I, DUAL_LINE_I, RESET_N_I} = '0;
    MODE_I = arp_pkg::MODE_PAR;
    ch_data = '0;
    cur = '0;
    repeat (8) @(posedge CLK_SYS_I);
    RESET_N_I <= 1'b1;
    repeat (10) @(posedge CLK_SYS_I);
    // Mode changes only while idle, since the straps cross domains.
    for (int i = 0; i < 6; i++) begin
      MODE_I <= (i < 2) ? arp_pkg::MODE_PAR : (i < 4) ? arp_pkg::MODE_BYTE : arp_pkg::MODE_SER;
      HI_FIRST_I <= (i == 2);
      DUAL_LINE_I <= (i == 5);
      prev = cur;
      cur = (i == 1) ? {8{16'h8001}} : {$random(seed), $random(seed), $random(seed), $random(seed)};
      ch_data <= cur;
      repeat (8) @(posedge CLK_SYS_I);
      TRIGGER_I <= 1'b1;
      @(posedge CLK_SYS_I);
      TRIGGER_I <= 1'b0;
      wait_busy(1'b1);
      if (i > 0) do_read(prev);
      wait_busy(1'b0);
      repeat (8) @(posedge CLK_SYS_I);
      fork
        do_read(cur);
        if (MODE_I == arp_pkg::MODE_BYTE) begin
          @(negedge lnk.rd_n);
          @(posedge lnk.link_clk);
          @(negedge lnk.link_clk);
          chk(128'(lnk.word_bus_in[7:0]), 128'(first_byte(cur[15:0], HI_FIRST_I)));
        end
      join
    end
    tally_and_finish();
  end
endmodule
